// [rtl/systm_counter.sv]
// Purpose: One up-counter with reload register and byte writes.
// Assumes: tick is a one-cycle count enable on clk.
// Notes: A software write to the live count beats a count tick.
`timescale 1ns/1ps
module systm_counter #(
	parameter int WIDTH = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Counting control
	input wire logic tick,
	input wire logic run,
	input wire logic reload_mode,
	// Byte write from software
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [7:0] wr_data,
	// State out
	output logic [WIDTH-1:0] count,
	output logic overflow
);
	// Live count and reload value
	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] reload_q;
	logic step;

	// Replace one byte of a word
	function automatic logic [WIDTH-1:0] put_byte(
		input logic [WIDTH-1:0] v,
		input logic [1:0] idx,
		input logic [7:0] b);
		logic [WIDTH-1:0] r;
		r = v;
		for (int k = 0; k < WIDTH / 8; k++)
		begin
			if (idx == 2'(k))
				r[k*8 +: 8] = b;
		end
		return r;
	endfunction

	// Count only when enabled and running
	assign step = clk_en && run && tick;
	// Overflow from all ones
	assign overflow = step && (&count_q);
	assign count = count_q;

	// Reload value takes writes in reload mode only
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			reload_q <= '0;
		else if (clk_en && wr_en && reload_mode)
			reload_q <= put_byte(reload_q, wr_idx, wr_data);
	end

	// Live counter
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			count_q <= '0;
		else if (clk_en && wr_en && !reload_mode)
			count_q <= put_byte(count_q, wr_idx, wr_data);
		else if (overflow)
			// Reload or wrap to zero
			count_q <= reload_mode ? reload_q : '0;
		else if (step)
			count_q <= count_q + WIDTH'(1);
	end
endmodule

// [rtl/systm_pkg.sv]
// Purpose: Shared constants for the three system timers.
// Assumes: Byte-wide register port with a 16-bit address.
// Notes: Bit positions index the byte-wide control registers.
package systm_pkg;
	// Counter and address widths
	localparam int NARROW_W = 16;
	localparam int WIDE_W = 24;
	localparam int ADDR_W = 16;
	// Register addresses
	localparam logic [15:0] A_LOW_ADDR = 16'h00AE;
	localparam logic [15:0] A_HIGH_ADDR = 16'h00AF;
	localparam logic [15:0] B_LOW_ADDR = 16'h00AC;
	localparam logic [15:0] B_HIGH_ADDR = 16'h00AD;
	localparam logic [15:0] DUAL_CTL_ADDR = 16'h00CF;
	localparam logic [15:0] W_CTL_ADDR = 16'hA003;
	localparam logic [15:0] W_LOW_ADDR = 16'hA004;
	localparam logic [15:0] W_MID_ADDR = 16'hA005;
	localparam logic [15:0] W_TOP_ADDR = 16'hA006;
	// Byte counts of each counter
	localparam logic [1:0] NARROW_BYTES = 2'h2;
	localparam logic [1:0] WIDE_BYTES = 2'h3;
	// Wide timer control fields
	localparam int W_FLAG_BIT = 7;
	localparam int W_SEL_HI_BIT = 6;
	localparam int W_SEL_LO_BIT = 5;
	localparam int W_MODE_BIT = 4;
	localparam int W_RUN_BIT = 3;
	localparam int W_IEN_BIT = 0;
	localparam logic [7:0] W_CTL_MASK = 8'hF9;
	// Dual timer control fields
	localparam int B_FLAG_BIT = 7;
	localparam int B_MODE_BIT = 6;
	localparam int B_RUN_BIT = 5;
	localparam int B_IEN_BIT = 4;
	localparam int A_FLAG_BIT = 3;
	localparam int A_MODE_BIT = 2;
	localparam int A_RUN_BIT = 1;
	localparam int A_IEN_BIT = 0;
	// Reset values
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
endpackage

// [rtl/systm_timers.sv]
// Purpose: Two 16-bit core-clock timers and one 24-bit timer.
// Assumes: Oscillator inputs are slow square waves, unrelated to clk.
// Notes: Counter reads are live; software reads high byte first.
// How it works
// - Narrow write hits reload or live count
// - Wide write hits reload or live count
// - Reads return live count, no snapshot
// - Timer A bytes at AE and AF
// - Timer B bytes at AC and AD
// - Wide timer bytes at A004 to A006
// - Wide control fields at A003
// - Select codes pick fast or slow oscillator
// - Wide mode bit picks reload or free-run
// - Counting only while run bit set
// - Wide overflow flag sticky until software write
// - Wide irq enable gates overflow request
// - Wide timer counts from its oscillator
// - Wide overflow serves as wake-up
// - Narrow timers count on core clock
// - Narrow timers have mode and run bits
// - Narrow overflow flags sticky until software write
// - Narrow irq enables gate overflow requests
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module systm_timers
(
	// Clock, reset, freeze
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Register port
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	// Oscillator pins
	input wire logic fast_internal_oscillator,
	input wire logic slow_internal_oscillator,
	// Requests
	output logic irq_timer_a,
	output logic irq_timer_b,
	output logic irq_wide_timer,
	output logic wake_wide_timer
);
	// Control registers
	logic [7:0] dual_ctl_q;
	logic [7:0] dual_ctl_d;
	logic [7:0] wide_ctl_q;
	logic [7:0] wide_ctl_d;
	// Read data and wake pulse
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic wake_q;
	// Oscillator synchronisers, three stages each
	logic [2:0] fast_sync_q;
	logic [2:0] slow_sync_q;
	// Filtered oscillator levels
	logic fast_lvl_q;
	logic slow_lvl_q;
	logic fast_rise;
	logic slow_rise;
	logic wide_tick;
	// Counter state
	logic [15:0] a_count;
	logic [15:0] b_count;
	logic [23:0] w_count;
	logic a_ovf;
	logic b_ovf;
	logic w_ovf;
	// Decoded writes
	logic a_wr;
	logic b_wr;
	logic w_wr;
	logic dual_wr;
	logic wctl_wr;
	logic [1:0] a_idx;
	logic [1:0] b_idx;
	logic [1:0] w_idx;

	// Address falls in a block of byte registers
	function automatic logic hit(
		input logic [15:0] a,
		input logic [15:0] base,
		input logic [1:0] n);
		return (a >= base) && ((a - base) < {14'h0000, n});
	endfunction

	// Byte position inside a block
	function automatic logic [1:0] offs(
		input logic [15:0] a,
		input logic [15:0] base);
		logic [15:0] d;
		d = a - base;
		return d[1:0];
	endfunction

	// Pick one byte of a live count
	function automatic logic [7:0] get_byte(
		input logic [23:0] v,
		input logic [1:0] i);
		return v[8*i +: 8];
	endfunction

	// Write decode
	assign a_wr = wr_en &&
		hit(addr, systm_pkg::A_LOW_ADDR, systm_pkg::NARROW_BYTES);
	assign b_wr = wr_en &&
		hit(addr, systm_pkg::B_LOW_ADDR, systm_pkg::NARROW_BYTES);
	assign w_wr = wr_en &&
		hit(addr, systm_pkg::W_LOW_ADDR, systm_pkg::WIDE_BYTES);
	assign dual_wr = wr_en && (addr == systm_pkg::DUAL_CTL_ADDR);
	assign wctl_wr = wr_en && (addr == systm_pkg::W_CTL_ADDR);
	assign a_idx = offs(addr, systm_pkg::A_LOW_ADDR);
	assign b_idx = offs(addr, systm_pkg::B_LOW_ADDR);
	assign w_idx = offs(addr, systm_pkg::W_LOW_ADDR);

	// Oscillator pins pass three flops; first stage feeds only the second
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			fast_sync_q <= 3'h0;
			slow_sync_q <= 3'h0;
		end
		else if (clk_en)
		begin
			fast_sync_q <= {fast_sync_q[1:0], fast_internal_oscillator};
			slow_sync_q <= {slow_sync_q[1:0], slow_internal_oscillator};
		end
	end

	// Level accepted once stages two and three agree
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			fast_lvl_q <= 1'b0;
			slow_lvl_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (fast_sync_q[1] == fast_sync_q[2])
				fast_lvl_q <= fast_sync_q[2];
			if (slow_sync_q[1] == slow_sync_q[2])
				slow_lvl_q <= slow_sync_q[2];
		end
	end

	// Rising edge of each filtered oscillator
	assign fast_rise = (fast_sync_q[1] == fast_sync_q[2]) &&
		fast_sync_q[2] && !fast_lvl_q;
	assign slow_rise = (slow_sync_q[1] == slow_sync_q[2]) &&
		slow_sync_q[2] && !slow_lvl_q;
	// Upper select bit chooses the slow source
	assign wide_tick = wide_ctl_q[systm_pkg::W_SEL_HI_BIT] ?
		slow_rise : fast_rise;

	// Timer A, counts every core clock
	systm_counter #(.WIDTH(systm_pkg::NARROW_W)) u_timer_a
	(
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.tick(1'b1),
		.run(dual_ctl_q[systm_pkg::A_RUN_BIT]),
		.reload_mode(dual_ctl_q[systm_pkg::A_MODE_BIT]),
		.wr_en(a_wr),
		.wr_idx(a_idx),
		.wr_data(wdata),
		.count(a_count),
		.overflow(a_ovf)
	);

	// Timer B, counts every core clock
	systm_counter #(.WIDTH(systm_pkg::NARROW_W)) u_timer_b
	(
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.tick(1'b1),
		.run(dual_ctl_q[systm_pkg::B_RUN_BIT]),
		.reload_mode(dual_ctl_q[systm_pkg::B_MODE_BIT]),
		.wr_en(b_wr),
		.wr_idx(b_idx),
		.wr_data(wdata),
		.count(b_count),
		.overflow(b_ovf)
	);

	// Wide timer, counts selected oscillator edges
	systm_counter #(.WIDTH(systm_pkg::WIDE_W)) u_wide
	(
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.tick(wide_tick),
		.run(wide_ctl_q[systm_pkg::W_RUN_BIT]),
		.reload_mode(wide_ctl_q[systm_pkg::W_MODE_BIT]),
		.wr_en(w_wr),
		.wr_idx(w_idx),
		.wr_data(wdata),
		.count(w_count),
		.overflow(w_ovf)
	);

	// Dual control next value; hardware set beats software clear
	always_comb
	begin
		dual_ctl_d = dual_ctl_q;
		if (dual_wr)
			dual_ctl_d = wdata;
		if (a_ovf)
			dual_ctl_d[systm_pkg::A_FLAG_BIT] = 1'b1;
		if (b_ovf)
			dual_ctl_d[systm_pkg::B_FLAG_BIT] = 1'b1;
	end

	// Wide control next value; unused bits stay zero
	always_comb
	begin
		wide_ctl_d = wide_ctl_q;
		if (wctl_wr)
			wide_ctl_d = wdata & systm_pkg::W_CTL_MASK;
		if (w_ovf)
			wide_ctl_d[systm_pkg::W_FLAG_BIT] = 1'b1;
	end

	// Control registers
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			dual_ctl_q <= systm_pkg::CTL_RESET;
			wide_ctl_q <= systm_pkg::CTL_RESET;
		end
		else if (clk_en)
		begin
			dual_ctl_q <= dual_ctl_d;
			wide_ctl_q <= wide_ctl_d;
		end
	end

	// Read mux; counts are live, never the reload value
	always_comb
	begin
		rdata_d = systm_pkg::RDATA_IDLE;
		if (!rd_en)
			rdata_d = systm_pkg::RDATA_IDLE;
		else if (hit(addr, systm_pkg::A_LOW_ADDR, systm_pkg::NARROW_BYTES))
			rdata_d = get_byte({8'h00, a_count}, a_idx);
		else if (hit(addr, systm_pkg::B_LOW_ADDR, systm_pkg::NARROW_BYTES))
			rdata_d = get_byte({8'h00, b_count}, b_idx);
		else if (hit(addr, systm_pkg::W_LOW_ADDR, systm_pkg::WIDE_BYTES))
			rdata_d = get_byte(w_count, w_idx);
		else if (addr == systm_pkg::DUAL_CTL_ADDR)
			rdata_d = dual_ctl_q;
		else if (addr == systm_pkg::W_CTL_ADDR)
			rdata_d = wide_ctl_q;
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			rdata_q <= systm_pkg::RDATA_IDLE;
		else if (clk_en)
			rdata_q <= rdata_d;
	end

	// Wake pulse regardless of irq enable, so sleep can end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			wake_q <= 1'b0;
		else if (clk_en)
			wake_q <= w_ovf;
	end

	// Outputs
	assign rdata = rdata_q;
	assign wake_wide_timer = wake_q;
	// Requests follow sticky flags gated by enables
	assign irq_timer_a = dual_ctl_q[systm_pkg::A_FLAG_BIT] &&
		dual_ctl_q[systm_pkg::A_IEN_BIT];
	assign irq_timer_b = dual_ctl_q[systm_pkg::B_FLAG_BIT] &&
		dual_ctl_q[systm_pkg::B_IEN_BIT];
	assign irq_wide_timer = wide_ctl_q[systm_pkg::W_FLAG_BIT] &&
		wide_ctl_q[systm_pkg::W_IEN_BIT];

	// Checks are paused while the block is frozen
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset || !clk_en);

	// Step sequences
	sequence s_read_a_low;
		rd_en && addr == systm_pkg::A_LOW_ADDR;
	endsequence
	sequence s_wide_free_wrap;
		w_ovf && !wide_ctl_q[systm_pkg::W_MODE_BIT] && !w_wr;
	endsequence
	sequence s_wide_flag_idle;
		wide_ctl_q[systm_pkg::W_FLAG_BIT] && !wctl_wr;
	endsequence

	// Live count of the strobe cycle is returned
	a_read_live: assert property (
		s_read_a_low |=> rdata == $past(a_count[7:0]))
		else $error("read byte not live count");

	// Wide overflow sets its flag
	a_wide_flag_set: assert property (
		w_ovf |=> wide_ctl_q[systm_pkg::W_FLAG_BIT])
		else $error("wide flag not set");

	// Flag holds until software writes control
	a_wide_flag_hold: assert property (
		s_wide_flag_idle |=> wide_ctl_q[systm_pkg::W_FLAG_BIT])
		else $error("wide flag dropped");

	// Request rises with flag when enabled
	a_wide_irq_gate: assert property (
		w_ovf && wide_ctl_q[systm_pkg::W_IEN_BIT] && !wctl_wr
		|=> irq_wide_timer ##0 wake_wide_timer)
		else $error("wide request missing");

	// Stopped wide timer holds its count
	a_wide_stop_hold: assert property (
		!wide_ctl_q[systm_pkg::W_RUN_BIT] && !w_wr && !wctl_wr
		|=> $stable(w_count))
		else $error("stopped wide timer moved");

	// Reload-mode write leaves live count alone
	a_a_reload_write: assert property (
		a_wr && a_idx == 2'h0 && dual_ctl_q[systm_pkg::A_MODE_BIT]
		&& !dual_ctl_q[systm_pkg::A_RUN_BIT] && !dual_wr
		|=> $stable(a_count) && u_timer_a.reload_q[7:0] == $past(wdata))
		else $error("reload write reached count");

	// Free-run write loads live count
	a_wide_free_write: assert property (
		w_wr && w_idx == 2'h0 && !wide_ctl_q[systm_pkg::W_MODE_BIT]
		|=> w_count[7:0] == $past(wdata))
		else $error("free write missed count");

	// Free-run overflow wraps to zero
	a_wide_free_wrap: assert property (
		s_wide_free_wrap |=> w_count == 24'h000000)
		else $error("free wrap not zero");

	// Narrow timer counts every cycle while running
	a_a_core_count: assert property (
		dual_ctl_q[systm_pkg::A_RUN_BIT] && !a_wr && !a_ovf && !dual_wr
		|=> a_count == $past(a_count) + 16'h0001)
		else $error("timer a missed a cycle");

	// Timer B overflow sets flag and request together
	a_b_flag_irq: assert property (
		b_ovf && dual_ctl_q[systm_pkg::B_IEN_BIT] && !dual_wr
		|=> dual_ctl_q[systm_pkg::B_FLAG_BIT] && irq_timer_b)
		else $error("timer b flag or request missing");
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the three system timers.
// Assumes: Byte register port, read data one cycle after the strobe.
// Notes: Oscillator levels last two clocks so the sync path sees each edge.
`timescale 1ns/1ps
module tb;
	logic clk, reset, clk_en, wr_en, rd_en; // Core clock and strobes
	logic [15:0] addr; // Register address
	logic [7:0] wdata, rdata, v; // Bus data and scratch
	logic osc_fast, osc_slow; // Oscillator pins
	logic irq_a, irq_b, irq_w, wake; // Request outputs
	int n_errors, checks_done, wakes; // Tallies
	systm_timers systm_timers_inst (.clk(clk), .reset(reset),
		.clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata),
		.fast_internal_oscillator(osc_fast),
		.slow_internal_oscillator(osc_slow), .irq_timer_a(irq_a),
		.irq_timer_b(irq_b), .irq_wide_timer(irq_w),
		.wake_wide_timer(wake));
	// Clock of 25 ns
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Wake pulses are single cycles, so count every one
	always @(posedge clk)
		if (wake === 1'b1)
			wakes <= wakes + 1;
	// Verdict in one place
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Byte comparison
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	// Single-cycle write strobe; returns off the edge so the
	// Caller sees flags and requests that the write has changed
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask
	// Read; data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask
	// Read and compare
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	// Whole oscillator periods, then let the sync path drain
	task automatic osc(input logic slow, input int n);
		for (int i = 0; i < n; i++)
		begin
			repeat (2) @(posedge clk);
			if (slow)
				osc_slow <= 1'b1;
			else
				osc_fast <= 1'b1;
			repeat (2) @(posedge clk);
			if (slow)
				osc_slow <= 1'b0;
			else
				osc_fast <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask
	// Bounded wait for a narrow timer request
	task automatic wait_irq(input logic b);
		int i;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk);
			if ((b ? irq_b : irq_a) === 1'b1)
				break;
		end
		if (i == 40)
		begin
			n_errors++;
			final_report();
		end
	endtask
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		final_report();
	end
	// Main sequence
	initial
	begin
		{reset, clk_en, wr_en, rd_en} = 4'b1100;
		{addr, wdata, osc_fast, osc_slow} = '0;
		{n_errors, checks_done, wakes} = '0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		// Reset values and an unmapped place
		rc(systm_pkg::A_LOW_ADDR, 8'h00);
		rc(systm_pkg::A_HIGH_ADDR, 8'h00);
		rc(systm_pkg::B_LOW_ADDR, 8'h00);
		rc(systm_pkg::B_HIGH_ADDR, 8'h00);
		rc(systm_pkg::W_CTL_ADDR, 8'h00);
		rc(systm_pkg::W_LOW_ADDR, 8'h00);
		rc(systm_pkg::W_MID_ADDR, 8'h00);
		rc(systm_pkg::W_TOP_ADDR, 8'h00);
		rc(16'h00B0, 8'h00);
		$display("test reset done");
		// Timer A: reload write, free write, reload on overflow
		wr(systm_pkg::DUAL_CTL_ADDR, 8'h04);
		wr(systm_pkg::A_LOW_ADDR, 8'hF0);
		wr(systm_pkg::A_HIGH_ADDR, 8'hFF);
		rc(systm_pkg::A_HIGH_ADDR, 8'h00);
		wr(systm_pkg::DUAL_CTL_ADDR, 8'h00);
		wr(systm_pkg::A_HIGH_ADDR, 8'hFF);
		wr(systm_pkg::A_LOW_ADDR, 8'hFD);
		rc(systm_pkg::A_HIGH_ADDR, 8'hFF);
		rc(systm_pkg::A_LOW_ADDR, 8'hFD);
		wr(systm_pkg::DUAL_CTL_ADDR, 8'h07);
		wait_irq(1'b0);
		wr(systm_pkg::DUAL_CTL_ADDR, 8'h05);
		chk("irq a cleared", 8'h00, {7'h00, irq_a});
		rc(systm_pkg::A_HIGH_ADDR, 8'hFF);
		rd(systm_pkg::A_LOW_ADDR, v);
		chk("a low upper nibble", 8'hF0, v & 8'hF0);
		rc(systm_pkg::A_LOW_ADDR, v);
		wr(systm_pkg::DUAL_CTL_ADDR, 8'h0C);
		chk("irq a masked", 8'h00, {7'h00, irq_a});
		wr(systm_pkg::DUAL_CTL_ADDR, 8'h0D);
		chk("irq a enabled", 8'h01, {7'h00, irq_a});
		rc(systm_pkg::DUAL_CTL_ADDR, 8'h0D);
		wr(systm_pkg::DUAL_CTL_ADDR, 8'h00);
		$display("test timer a done");
		// Timer B: free-run wraps to zero
		wr(systm_pkg::B_HIGH_ADDR, 8'hFF);
		wr(systm_pkg::B_LOW_ADDR, 8'hFE);
		rc(systm_pkg::B_LOW_ADDR, 8'hFE);
		wr(systm_pkg::DUAL_CTL_ADDR, 8'h30);
		wait_irq(1'b1);
		wr(systm_pkg::DUAL_CTL_ADDR, 8'h10);
		chk("irq b cleared", 8'h00, {7'h00, irq_b});
		rc(systm_pkg::B_HIGH_ADDR, 8'h00);
		$display("test timer b done");
		// Wide timer free-run overflow from the fast source
		wr(systm_pkg::W_LOW_ADDR, 8'hFD);
		wr(systm_pkg::W_MID_ADDR, 8'hFF);
		wr(systm_pkg::W_TOP_ADDR, 8'hFF);
		rc(systm_pkg::W_TOP_ADDR, 8'hFF);
		wr(systm_pkg::W_CTL_ADDR, 8'h09);
		osc(1'b0, 3);
		rc(systm_pkg::W_CTL_ADDR, 8'h89);
		chk("irq wide", 8'h01, {7'h00, irq_w});
		chk("wake count", 8'h01, wakes[7:0]);
		rc(systm_pkg::W_TOP_ADDR, 8'h00);
		rc(systm_pkg::W_LOW_ADDR, 8'h00);
		wr(systm_pkg::W_CTL_ADDR, 8'h00);
		chk("irq wide cleared", 8'h00, {7'h00, irq_w});
		// Reload mode, slow source, request masked
		wr(systm_pkg::W_CTL_ADDR, 8'h10);
		wr(systm_pkg::W_LOW_ADDR, 8'h56);
		wr(systm_pkg::W_MID_ADDR, 8'h34);
		wr(systm_pkg::W_TOP_ADDR, 8'h12);
		rc(systm_pkg::W_LOW_ADDR, 8'h00);
		wr(systm_pkg::W_CTL_ADDR, 8'h00);
		wr(systm_pkg::W_LOW_ADDR, 8'hFE);
		wr(systm_pkg::W_MID_ADDR, 8'hFF);
		wr(systm_pkg::W_TOP_ADDR, 8'hFF);
		wr(systm_pkg::W_CTL_ADDR, 8'h78);
		osc(1'b0, 2);
		rc(systm_pkg::W_LOW_ADDR, 8'hFE);
		osc(1'b1, 2);
		rc(systm_pkg::W_TOP_ADDR, 8'h12);
		rc(systm_pkg::W_MID_ADDR, 8'h34);
		rc(systm_pkg::W_LOW_ADDR, 8'h56);
		rc(systm_pkg::W_CTL_ADDR, 8'hF8);
		chk("irq wide masked", 8'h00, {7'h00, irq_w});
		chk("wake count", 8'h02, wakes[7:0]);
		// Remaining select codes, then a stopped count holds
		wr(systm_pkg::W_CTL_ADDR, 8'h28);
		osc(1'b0, 1);
		rc(systm_pkg::W_LOW_ADDR, 8'h57);
		wr(systm_pkg::W_CTL_ADDR, 8'h48);
		osc(1'b1, 1);
		rc(systm_pkg::W_LOW_ADDR, 8'h58);
		wr(systm_pkg::W_CTL_ADDR, 8'h40);
		osc(1'b1, 2);
		rc(systm_pkg::W_LOW_ADDR, 8'h58);
		// Unused bits read back as zero
		wr(systm_pkg::W_CTL_ADDR, 8'hFF);
		rc(systm_pkg::W_CTL_ADDR, 8'hF9);
		wr(systm_pkg::W_CTL_ADDR, 8'h00);
		$display("test wide timer done");
		// Frozen block ignores oscillator edges and strobes
		wr(systm_pkg::W_CTL_ADDR, 8'h08);
		@(posedge clk);
		clk_en <= 1'b0;
		osc(1'b0, 2);
		wr(systm_pkg::W_LOW_ADDR, 8'h00);
		@(posedge clk);
		clk_en <= 1'b1;
		rc(systm_pkg::W_LOW_ADDR, 8'h58);
		// Read data fall back to idle one cycle later
		@(posedge clk);
		#1 chk("read data idle", 8'h00, rdata);
		// Counting resumes once the freeze ends
		osc(1'b0, 1);
		rc(systm_pkg::W_LOW_ADDR, 8'h59);
		wr(systm_pkg::W_CTL_ADDR, 8'h00);
		$display("test freeze done");
		final_report();
	end
endmodule
